// ===== hdl/pbu_defs.vh
`ifndef PBU_DEFS_VH
`define PBU_DEFS_VH

// register byte offsets
`define PBU_OFS_FUNC 8'h00
`define PBU_OFS_DIR 8'h04
`define PBU_OFS_DOUT 8'h08
`define PBU_OFS_PIN 8'h0C

// power-on reset values
`define PBU_RST_FUNC 16'h0000
`define PBU_RST_DIR 8'h00
`define PBU_RST_DOUT 8'h00

// pin field codes
`define PBU_CODE_GIO 2'h0
`define PBU_CODE_ALT1 2'h1
`define PBU_CODE_ALT2 2'h2
`define PBU_CODE_PAT 2'h3

// alternate function kinds
`define PBU_KIND_RSVD 3'h0
`define PBU_KIND_IRQ 3'h1
`define PBU_KIND_SCK 3'h2
`define PBU_KIND_TX 3'h3
`define PBU_KIND_RX 3'h4

// level forwarded to a peripheral input that is not routed to its pin
`define PBU_FWD_IDLE 1'h1

// bus answers
`define PBU_RESP_OKAY 2'h0
`define PBU_RESP_SLVERR 2'h2

`endif

// ===== hdl/pbu_pin_cell.v
`timescale 1ns/10ps
`include "pbu_defs.vh"

module pbu_pin_cell #(
	parameter [2:0] KIND01 = `PBU_KIND_RSVD,
	parameter [2:0] KIND10 = `PBU_KIND_RSVD
) (
	// clock, reset, enable
	input wire mclk,
	input wire rst_b,
	input wire ce,
	// selection and data
	input wire [1:0] field,
	input wire dirBit,
	input wire gioData,
	input wire pinSync,
	input wire altOut,
	input wire patOut,
	// registered results
	output reg pinOut,
	output reg pinOe,
	output reg fwd01,
	output reg fwd10
);

reg pinOut_next;
reg pinOe_next;

////////////////////////////////////////////////////////////////////////////
// drive enable of one alternate function
function altOe;
	input [2:0] kind;
	input dir;
	begin
		case (kind)
			`PBU_KIND_TX: altOe = 1'b1;
			`PBU_KIND_SCK: altOe = dir;
			default: altOe = 1'b0;
		endcase
	end
endfunction

function isInput;
	input [2:0] kind;
	begin
		isInput = (kind == `PBU_KIND_IRQ) || (kind == `PBU_KIND_RX) ||
			(kind == `PBU_KIND_SCK);
	end
endfunction

always @* begin
	pinOut_next = 1'b0;
	pinOe_next = 1'b0;
	case (field)
		`PBU_CODE_GIO: begin
			pinOut_next = gioData;
			pinOe_next = dirBit;
		end
		`PBU_CODE_ALT1: begin
			pinOut_next = altOut;
			pinOe_next = altOe(KIND01, dirBit);
		end
		`PBU_CODE_ALT2: begin
			pinOut_next = altOut;
			pinOe_next = altOe(KIND10, dirBit);
		end
		default: begin
			pinOut_next = patOut;
			pinOe_next = 1'b1;
		end
	endcase
end

////////////////////////////////////////////////////////////////////////////
// output stage; reserved codes leave the pin undriven
always @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		pinOut <= 1'b0;
		pinOe <= 1'b0;
		fwd01 <= `PBU_FWD_IDLE;
		fwd10 <= `PBU_FWD_IDLE;
	end else if (ce) begin
		pinOut <= pinOut_next;
		pinOe <= pinOe_next;
		if (field == `PBU_CODE_ALT1 && isInput(KIND01))
			fwd01 <= pinSync;
		else
			fwd01 <= `PBU_FWD_IDLE;
		if (field == `PBU_CODE_ALT2 && isInput(KIND10))
			fwd10 <= pinSync;
		else
			fwd10 <= `PBU_FWD_IDLE;
	end
end

endmodule // pbu_pin_cell

// ===== hdl/pbu_pin_mux.v
`timescale 1ns/10ps
`include "pbu_defs.vh"

module pbu_pin_mux #(
	parameter ADDR_W = 8
) (
	// clock, reset, enable
	input wire mclk,
	input wire rst_b,
	input wire ce,
	// AXI4-Lite write address
	input wire s_awvalid,
	output reg s_awready,
	input wire [ADDR_W-1:0] s_awaddr,
	input wire [2:0] s_awprot,
	// AXI4-Lite write data
	input wire s_wvalid,
	output reg s_wready,
	input wire [31:0] s_wdata,
	input wire [3:0] s_wstrb,
	// AXI4-Lite write response
	output reg s_bvalid,
	input wire s_bready,
	output reg [1:0] s_bresp,
	// AXI4-Lite read address
	input wire s_arvalid,
	output reg s_arready,
	input wire [ADDR_W-1:0] s_araddr,
	input wire [2:0] s_arprot,
	// AXI4-Lite read data
	output reg s_rvalid,
	input wire s_rready,
	output reg [31:0] s_rdata,
	output reg [1:0] s_rresp,
	// port pins 15..8, index 0 is pin 8
	input wire [7:0] portPinIn,
	output wire [7:0] portPinOut,
	output wire [7:0] portPinOe,
	// timing pattern unit
	input wire [7:0] patternOut,
	// serial channels
	input wire serial0TransmitOut,
	input wire serial1TransmitOut,
	input wire serial0ClockOut,
	input wire serial1ClockOut,
	output wire serial0ReceiveIn,
	output wire serial1ReceiveIn,
	output wire serial0ClockIn,
	output wire serial1ClockIn,
	// external interrupt requests 7..4, index 0 is request 4
	output wire [3:0] extIntReq
);

////////////////////////////////////////////////////////////////////////////
// registers and internal state
reg [15:0] funcSel_reg;
reg [7:0] dir_reg;
reg [7:0] dout_reg;
reg [7:0] pinMeta_reg;
reg [7:0] pinSync_reg;
reg [ADDR_W-1:0] awAddr_reg;
reg awHeld_reg;
reg [31:0] wData_reg;
reg [3:0] wStrb_reg;
reg wHeld_reg;
wire [7:0] fwd01;
wire [7:0] fwd10;
wire [7:0] altOutVec;
wire wrFire;
reg [15:0] funcSel_next;
reg [7:0] dir_next;
reg [7:0] dout_next;
reg [31:0] rData_next;

////////////////////////////////////////////////////////////////////////////
// pin function tables, index 0 is pin 8
function [2:0] kind01;
	input integer idx;
	begin
		case (idx)
			4: kind01 = `PBU_KIND_IRQ;
			5: kind01 = `PBU_KIND_IRQ;
			6: kind01 = `PBU_KIND_IRQ;
			7: kind01 = `PBU_KIND_IRQ;
			default: kind01 = `PBU_KIND_RSVD;
		endcase
	end
endfunction

function [2:0] kind10;
	input integer idx;
	begin
		case (idx)
			0: kind10 = `PBU_KIND_RX;
			1: kind10 = `PBU_KIND_TX;
			2: kind10 = `PBU_KIND_RX;
			3: kind10 = `PBU_KIND_TX;
			4: kind10 = `PBU_KIND_SCK;
			5: kind10 = `PBU_KIND_SCK;
			default: kind10 = `PBU_KIND_RSVD;
		endcase
	end
endfunction

// word select shared by both bus channels
function [1:0] decodeIdx;
	input [ADDR_W-1:0] addr;
	begin
		decodeIdx = addr[3:2];
	end
endfunction

function isMapped;
	input [ADDR_W-1:0] addr;
	begin
		isMapped = (addr[ADDR_W-1:4] == {(ADDR_W-4){1'b0}});
	end
endfunction

// hit on one register word; addr[1:0] is ignored
function isReg;
	input [ADDR_W-1:0] addr;
	input [7:0] ofs;
	begin
		isReg = isMapped(addr) && (decodeIdx(addr) == ofs[3:2]);
	end
endfunction

////////////////////////////////////////////////////////////////////////////
// peripheral outputs routed to pins by the alternate codes
assign altOutVec = {2'b00, serial1ClockOut, serial0ClockOut,
	serial1TransmitOut, 1'b0, serial0TransmitOut, 1'b0};

// a write lands once address and data are both held
assign wrFire = awHeld_reg && wHeld_reg && !s_bvalid;

////////////////////////////////////////////////////////////////////////////
// pin input synchroniser
always @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		pinMeta_reg <= 8'h00;
		pinSync_reg <= 8'h00;
	end else if (ce) begin
		pinMeta_reg <= portPinIn;
		pinSync_reg <= pinMeta_reg;
	end
end

////////////////////////////////////////////////////////////////////////////
// one mux cell per pin
genvar gi;
generate
	for (gi = 0; gi < 8; gi = gi + 1) begin : gCell
		pbu_pin_cell #(
			.KIND01(kind01(gi)),
			.KIND10(kind10(gi))
		) uCell (
			.mclk(mclk),
			.rst_b(rst_b),
			.ce(ce),
			.field(funcSel_reg[2*gi+1:2*gi]),
			.dirBit(dir_reg[gi]),
			.gioData(dout_reg[gi]),
			.pinSync(pinSync_reg[gi]),
			.altOut(altOutVec[gi]),
			.patOut(patternOut[gi]),
			.pinOut(portPinOut[gi]),
			.pinOe(portPinOe[gi]),
			.fwd01(fwd01[gi]),
			.fwd10(fwd10[gi])
		);
	end
endgenerate

assign extIntReq = fwd01[7:4];
assign serial0ReceiveIn = fwd10[0];
assign serial1ReceiveIn = fwd10[2];
assign serial0ClockIn = fwd10[4];
assign serial1ClockIn = fwd10[5];

////////////////////////////////////////////////////////////////////////////
// register write decode; unmapped and read-only words change nothing
always @* begin
	funcSel_next = funcSel_reg;
	dir_next = dir_reg;
	dout_next = dout_reg;
	if (wrFire) begin
		if (isReg(awAddr_reg, `PBU_OFS_FUNC)) begin
			if (wStrb_reg[0])
				funcSel_next[7:0] = wData_reg[7:0];
			if (wStrb_reg[1])
				funcSel_next[15:8] = wData_reg[15:8];
		end else if (isReg(awAddr_reg, `PBU_OFS_DIR)) begin
			if (wStrb_reg[0])
				dir_next = wData_reg[7:0];
		end else if (isReg(awAddr_reg, `PBU_OFS_DOUT)) begin
			if (wStrb_reg[0])
				dout_next = wData_reg[7:0];
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// control registers, cleared by power-on reset only
always @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		funcSel_reg <= `PBU_RST_FUNC;
		dir_reg <= `PBU_RST_DIR;
		dout_reg <= `PBU_RST_DOUT;
	end else if (ce) begin
		funcSel_reg <= funcSel_next;
		dir_reg <= dir_next;
		dout_reg <= dout_next;
	end
end

////////////////////////////////////////////////////////////////////////////
// write channel: address and data taken in either order
always @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		s_awready <= 1'b1;
		s_wready <= 1'b1;
		s_bvalid <= 1'b0;
		s_bresp <= `PBU_RESP_OKAY;
		awAddr_reg <= {ADDR_W{1'b0}};
		awHeld_reg <= 1'b0;
		wData_reg <= 32'h00000000;
		wStrb_reg <= 4'h0;
		wHeld_reg <= 1'b0;
	end else if (ce) begin
		if (s_awvalid && s_awready) begin
			awAddr_reg <= s_awaddr;
			awHeld_reg <= 1'b1;
			s_awready <= 1'b0;
		end
		if (s_wvalid && s_wready) begin
			wData_reg <= s_wdata;
			wStrb_reg <= s_wstrb;
			wHeld_reg <= 1'b1;
			s_wready <= 1'b0;
		end
		if (wrFire) begin
			s_bvalid <= 1'b1;
			if (isMapped(awAddr_reg))
				s_bresp <= `PBU_RESP_OKAY;
			else
				s_bresp <= `PBU_RESP_SLVERR;
		end
		if (s_bvalid && s_bready) begin
			s_bvalid <= 1'b0;
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			s_awready <= 1'b1;
			s_wready <= 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// read word select; reserved bits and unmapped words read as zero
always @* begin
	rData_next = 32'h00000000;
	if (isReg(s_araddr, `PBU_OFS_FUNC))
		rData_next = {16'h0000, funcSel_reg};
	else if (isReg(s_araddr, `PBU_OFS_DIR))
		rData_next = {24'h000000, dir_reg};
	else if (isReg(s_araddr, `PBU_OFS_DOUT))
		rData_next = {24'h000000, dout_reg};
	else if (isReg(s_araddr, `PBU_OFS_PIN))
		rData_next = {24'h000000, pinSync_reg};
end

////////////////////////////////////////////////////////////////////////////
// read channel
always @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		s_arready <= 1'b1;
		s_rvalid <= 1'b0;
		s_rdata <= 32'h00000000;
		s_rresp <= `PBU_RESP_OKAY;
	end else if (ce) begin
		if (s_arvalid && s_arready) begin
			s_arready <= 1'b0;
			s_rvalid <= 1'b1;
			s_rdata <= rData_next;
			if (isMapped(s_araddr))
				s_rresp <= `PBU_RESP_OKAY;
			else
				s_rresp <= `PBU_RESP_SLVERR;
		end else if (s_rvalid && s_rready) begin
			s_rvalid <= 1'b0;
			s_arready <= 1'b1;
		end
	end
end

endmodule // pbu_pin_mux

// ===== tb/pbu_pin_mux_asserts.sv
`timescale 1ns/10ps
module pbu_pin_mux_asserts (
	// clock and reset
	input wire mclk,
	input wire rst_b,
	// bus
	input wire s_awvalid,
	input wire s_awready,
	input wire s_wvalid,
	input wire s_wready,
	input wire s_bvalid,
	input wire s_bready,
	input wire s_arvalid,
	input wire s_arready,
	input wire [7:0] s_araddr,
	input wire s_rvalid,
	input wire s_rready,
	input wire [31:0] s_rdata,
	input wire [1:0] s_rresp,
	// pins
	input wire [7:0] portPinOe,
	input wire [3:0] extIntReq
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
		else $error("read answer missing");
	a_read_busy: assert property (s_rvalid |-> !s_arready)
		else $error("read taken while busy");
	a_read_stands: assert property (s_rvalid && !s_rready |=>
		s_rvalid && $stable(s_rdata)) else $error("read data dropped");
	a_unmapped_read: assert property (s_arvalid && s_arready &&
		s_araddr[7:4] != 4'h0 |=> s_rresp == 2'h2 && s_rdata == 32'h0)
		else $error("unmapped read answered");
	a_write_answer: assert property (s_awvalid && s_awready &&
		s_wvalid && s_wready |-> ##[1:2] s_bvalid)
		else $error("write answer missing");
	a_write_busy: assert property (s_bvalid |-> !s_awready && !s_wready)
		else $error("write taken while busy");
	a_write_stands: assert property (s_bvalid && !s_bready |=> s_bvalid)
		else $error("write answer dropped");
	a_reset_idle: assert property ($rose(rst_b) |->
		portPinOe == 8'h00 && extIntReq == 4'hF)
		else $error("pins not idle after reset");
endmodule // pbu_pin_mux_asserts
////////////////////////////////////////////////////////////////////////////
bind pbu_pin_mux pbu_pin_mux_asserts chk (
	.mclk(mclk), .rst_b(rst_b), .s_awvalid(s_awvalid),
	.s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready),
	.s_bvalid(s_bvalid), .s_bready(s_bready), .s_arvalid(s_arvalid),
	.s_arready(s_arready), .s_araddr(s_araddr), .s_rvalid(s_rvalid),
	.s_rready(s_rready), .s_rdata(s_rdata), .s_rresp(s_rresp),
	.portPinOe(portPinOe), .extIntReq(extIntReq)
);

// ===== tb/pbu_pin_mux_test.sv
`timescale 1ns/10ps
module pbu_pin_mux_test;
	logic mclk = 0, rst_b = 0, awv = 0, wv = 0, bRdy = 0, arv = 0, rRdy = 0;
	logic [7:0] awa = 8'h00, ara = 8'h00, pinIn = 8'h96, pat = 8'h5A;
	logic [31:0] wd = 32'h0;
	logic [3:0] ws = 4'h0;
	logic tx0 = 1, tx1 = 0, ck0 = 0, ck1 = 1;
	logic ce = 1;
	wire awRdy, wRdy, bValid, arRdy, rValid, rx0, rx1, ckIn0, ckIn1;
	wire [1:0] bResp, rResp;
	wire [31:0] rData;
	wire [7:0] pinOut, pinOe;
	wire [3:0] irq;
	int nFail = 0, testsRun = 0, cyc = 0;
	// function words that never hold a reserved code, and pin state for each
	logic [15:0] fncT[4] = '{16'h0000, 16'h5500, 16'h0AAA, 16'hFFFF};
	logic [7:0] oeT[4] = '{8'hA5, 8'h05, 8'hAA, 8'hFF};
	logic [7:0] outT[4] = '{8'h24, 8'h04, 8'h22, 8'h5A};
	logic [3:0] irqT[4] = '{4'hF, 4'h9, 4'hF, 4'hF};
	logic [3:0] fwdT[4] = '{4'hF, 4'hF, 4'h9, 4'hF};
	pbu_pin_mux #(.ADDR_W(8)) dut (
		.mclk(mclk), .rst_b(rst_b), .ce(ce),
		.s_awvalid(awv), .s_awready(awRdy), .s_awaddr(awa), .s_awprot(3'h0),
		.s_wvalid(wv), .s_wready(wRdy), .s_wdata(wd), .s_wstrb(ws),
		.s_bvalid(bValid), .s_bready(bRdy), .s_bresp(bResp),
		.s_arvalid(arv), .s_arready(arRdy), .s_araddr(ara), .s_arprot(3'h0),
		.s_rvalid(rValid), .s_rready(rRdy), .s_rdata(rData), .s_rresp(rResp),
		.portPinIn(pinIn), .portPinOut(pinOut), .portPinOe(pinOe),
		.patternOut(pat), .serial0TransmitOut(tx0), .serial1TransmitOut(tx1),
		.serial0ClockOut(ck0), .serial1ClockOut(ck1),
		.serial0ReceiveIn(rx0), .serial1ReceiveIn(rx1),
		.serial0ClockIn(ckIn0), .serial1ClockIn(ckIn1), .extIntReq(irq)
	);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			nFail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s,
		logic [1:0] er);
		@(posedge mclk);
		awa <= a;
		wd <= d;
		ws <= s;
		awv <= 1;
		wv <= 1;
		bRdy <= 1;
		do begin
			@(posedge mclk);
			if (awRdy) awv <= 0;
			if (wRdy) wv <= 0;
		end while (bValid !== 1'b1);
		bRdy <= 0;
		chk("bresp", bResp, er);
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] exp, logic [1:0] er);
		@(posedge mclk);
		ara <= a;
		arv <= 1;
		rRdy <= 1;
		do begin
			@(posedge mclk);
			if (arRdy) arv <= 0;
		end while (rValid !== 1'b1);
		rRdy <= 0;
		chk("rdata", rData, exp);
		chk("rresp", rResp, er);
	endtask
	task results;
		if (nFail == 0 && testsRun > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	always #10 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			nFail++;
			results;
		end
	end
	initial begin
		repeat (8) @(posedge mclk);
		rst_b <= 1;
		rd(8'h00, 32'h0, 2'h0);
		wr(8'h04, 32'hA5, 4'hF, 2'h0);
		wr(8'h08, 32'h3C, 4'hF, 2'h0);
		rd(8'h04, 32'hA5, 2'h0);
		rd(8'h08, 32'h3C, 2'h0);
		for (int c = 0; c < 4; c++) begin
			wr(8'h00, {16'h0, fncT[c]}, 4'hF, 2'h0);
			rd(8'h00, {16'h0, fncT[c]}, 2'h0);
			// routing and forwarded inputs settle one edge after the register; a pin change takes three
			repeat (4) @(posedge mclk);
			chk("oe", pinOe, oeT[c]);
			chk("out", pinOut & pinOe, outT[c]);
			chk("irq", irq, irqT[c]);
			chk("fwd", {rx1, rx0, ckIn1, ckIn0}, fwdT[c]);
		end
		wr(8'h00, 32'h0, 4'h2, 2'h0);
		rd(8'h00, 32'hFF, 2'h0);
		wr(8'h10, 32'h0, 4'hF, 2'h2);
		rd(8'h20, 32'h0, 2'h2);
		wr(8'h0C, 32'h0, 4'hF, 2'h0);
		rd(8'h0C, 32'h96, 2'h0);
		// a low enable freezes the synchroniser along with everything else
		ce <= 0;
		pinIn <= 8'h69;
		repeat (4) @(posedge mclk);
		ce <= 1;
		rd(8'h0C, 32'h96, 2'h0);
		rd(8'h0C, 32'h69, 2'h0);
		rd(8'h00, 32'hFF, 2'h0);
		rst_b <= 0;
		repeat (2) @(posedge mclk);
		rst_b <= 1;
		rd(8'h00, 32'h0, 2'h0);
		chk("oe", pinOe, 32'h0);
		results;
	end
endmodule // pbu_pin_mux_test
